//--- rtl/boiler_sequence_controller.sv
// Boiler sequencer top: APB registers, purge, limit, ignition, overrun
`timescale 1ns/1ns
module boiler_sequence_controller (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic heat_call,
	input wire logic [7:0] water_temp,
	input wire logic air_proven,
	input wire logic flame_sense,
	input wire logic hot_water_draw_input,
	output logic blower_on,
	output logic boiler_circulator_output,
	output logic gas_valve_on,
	output logic igniter_on,
	output logic [23:0] display_chars,
	output logic irq
);
	tick_if tk (); // One-second enable
	logic fast_cool; // Cooling faster than allowed

	// Settings, event and mask registers
	logic [7:0] hilim_q;
	logic [7:0] diff_q;
	logic [7:0] ptemp_q;
	logic [7:0] pdly_q;
	logic [7:0] ovr_q;
	logic purge_en_q;
	logic [3:0] irq_q; // Sticky events
	logic [3:0] mask_q; // Event enables

	// Sequencer state
	boiler_pkg::seq_t st_q;
	logic limit_q; // High limit tripped
	logic [7:0] start_temp_q; // Temp at call start
	logic [7:0] sec_q; // Phase seconds
	logic [1:0] fails_q; // Failed trials
	logic [7:0] ovr_cnt_q; // Overrun seconds left
	logic air_err_q; // Airflow fault shown
	logic heat_d1_q; // Previous call for heat
	logic [3:0] ev; // Event pulses this cycle

	sec_divider u_div (
		.clk(clk),
		.arst_n(arst_n),
		.tk(tk)
	);

	temp_rate u_rate (
		.clk(clk),
		.arst_n(arst_n),
		.tk(tk),
		.temp(water_temp),
		.run(boiler_circulator_output),
		.fast_cool(fast_cool)
	);

	// APB access phase
	logic wr_en;
	assign wr_en = psel && penable && pwrite;

	// Clamp a write into the documented setting range
	function automatic logic [7:0] clamp(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction : clamp

	// Settings writes; out-of-range values are clamped, not refused
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hilim_q <= boiler_pkg::HILIM_RST;
			diff_q <= boiler_pkg::DIFF_RST;
			ptemp_q <= boiler_pkg::PTEMP_RST;
			pdly_q <= boiler_pkg::PDLY_RST;
			ovr_q <= boiler_pkg::OVR_RST; // RULE12
			purge_en_q <= 1'b1;
			mask_q <= 4'h0;
		end
		else if (wr_en)
		begin
			if (paddr == boiler_pkg::OFF_HILIM)
				hilim_q <= clamp(pwdata[7:0], boiler_pkg::HILIM_MIN,
					boiler_pkg::HILIM_MAX); // RULE3
			else if (paddr == boiler_pkg::OFF_DIFF)
				diff_q <= clamp(pwdata[7:0], boiler_pkg::DIFF_MIN,
					boiler_pkg::DIFF_MAX); // RULE4
			else if (paddr == boiler_pkg::OFF_PTEMP)
				ptemp_q <= pwdata[7:0]; // RULE6
			else if (paddr == boiler_pkg::OFF_PDLY)
				pdly_q <= pwdata[7:0]; // RULE6
			else if (paddr == boiler_pkg::OFF_OVR)
				ovr_q <= clamp(pwdata[7:0], 8'h00,
					boiler_pkg::OVR_MAX); // RULE12
			else if (paddr == boiler_pkg::OFF_CTRL)
				purge_en_q <= pwdata[boiler_pkg::CTRL_PURGE_EN]; // RULE10
			else if (paddr == boiler_pkg::OFF_MASK)
				mask_q <= pwdata[3:0];
		end
	end

	// Read mux and bus answer, one wait-free access phase
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable)
			begin
				// Unmapped offsets answer with an error
				if (paddr == boiler_pkg::OFF_HILIM)
					prdata <= {24'h00_0000, hilim_q};
				else if (paddr == boiler_pkg::OFF_DIFF)
					prdata <= {24'h00_0000, diff_q};
				else if (paddr == boiler_pkg::OFF_PTEMP)
					prdata <= {24'h00_0000, ptemp_q};
				else if (paddr == boiler_pkg::OFF_PDLY)
					prdata <= {24'h00_0000, pdly_q};
				else if (paddr == boiler_pkg::OFF_OVR)
					prdata <= {24'h00_0000, ovr_q};
				else if (paddr == boiler_pkg::OFF_CTRL)
					prdata <= {31'h0000_0000, purge_en_q};
				else if (paddr == boiler_pkg::OFF_STAT)
					prdata <= {16'h0000, 3'h0, limit_q, air_err_q,
						fails_q, 1'b0, 5'h00, st_q};
				else if (paddr == boiler_pkg::OFF_IRQ)
					prdata <= {28'h000_0000, irq_q};
				else if (paddr == boiler_pkg::OFF_MASK)
					prdata <= {28'h000_0000, mask_q};
				else if (paddr == boiler_pkg::OFF_DISP)
					prdata <= {8'h00, display_chars};
				else
					pslverr <= 1'b1;
			end
		end
	end

	// Sticky events, write one to clear; a new event wins over the clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_q <= 4'h0;
		else if (wr_en && paddr == boiler_pkg::OFF_IRQ)
			irq_q <= (irq_q & ~pwdata[3:0]) | ev;
		else
			irq_q <= irq_q | ev;
	end

	// Level interrupt from a flop
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |((irq_q | ev) & mask_q);
	end

	// High limit with hysteresis
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			limit_q <= 1'b0;
		else if (water_temp > hilim_q)
			limit_q <= 1'b1; // RULE3
		else if ({1'b0, water_temp} + {1'b0, diff_q} < {1'b0, hilim_q})
			limit_q <= 1'b0; // RULE4
	end

	// Purge release: temperature, delay, 10F drop, fast cooling, draw
	logic purge_done;
	assign purge_done = !purge_en_q || hot_water_draw_input || // RULE9 RULE10
		(water_temp < ptemp_q) || (sec_q >= pdly_q) || // RULE5 RULE6
		({1'b0, water_temp} + {1'b0, boiler_pkg::PURGE_DROP} <=
		{1'b0, start_temp_q}) || fast_cool; // RULE7 RULE8

	// Main sequencer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= boiler_pkg::ST_IDLE;
			sec_q <= 8'h00;
			fails_q <= 2'h0;
			start_temp_q <= 8'h00;
			air_err_q <= 1'b0;
			heat_d1_q <= 1'b0;
			ev <= 4'h0;
		end
		else
		begin
			heat_d1_q <= heat_call;
			ev <= 4'h0;
			if (tk.sec_tick && sec_q != 8'hFF)
				sec_q <= sec_q + 8'h01;
			case (st_q)
			boiler_pkg::ST_IDLE:
			begin
				// Capture temperature at call start
				if (heat_call && !heat_d1_q)
					start_temp_q <= water_temp; // RULE7
				if (heat_call)
				begin
					st_q <= boiler_pkg::ST_PURGE; // RULE5
					sec_q <= 8'h00;
				end
			end
			boiler_pkg::ST_PURGE:
			begin
				if (!heat_call)
					st_q <= boiler_pkg::ST_IDLE;
				else if (purge_done && !limit_q)
				begin
					st_q <= boiler_pkg::ST_PROVE; // RULE19
					sec_q <= 8'h00;
				end
			end
			boiler_pkg::ST_PROVE:
			begin
				// Blower on; wait for switch to close
				if (!heat_call || limit_q)
					st_q <= boiler_pkg::ST_IDLE;
				else if (air_proven)
				begin
					air_err_q <= 1'b0;
					st_q <= boiler_pkg::ST_TRIAL; // RULE19
					sec_q <= 8'h00;
				end
				else if (sec_q >= 8'(boiler_pkg::PROVE_S))
				begin
					if (!air_err_q)
						ev[boiler_pkg::IRQ_AIR] <= 1'b1;
					air_err_q <= 1'b1; // RULE16
				end
			end
			boiler_pkg::ST_TRIAL:
			begin
				if (!air_proven || !heat_call || limit_q)
				begin
					// Fresh proving timeout, not the trial's leftover seconds
					st_q <= boiler_pkg::ST_PROVE; // RULE17
					sec_q <= 8'h00;
				end
				else if (sec_q >= 8'(boiler_pkg::TRIAL_S))
				begin
					if (flame_sense)
					begin
						fails_q <= 2'h0; // RULE14
						st_q <= boiler_pkg::ST_RUN;
					end
					else if (fails_q == boiler_pkg::MAX_TRIALS - 2'h1)
					begin
						fails_q <= boiler_pkg::MAX_TRIALS;
						ev[boiler_pkg::IRQ_LOCK] <= 1'b1;
						st_q <= boiler_pkg::ST_LOCK; // RULE15
					end
					else
					begin
						fails_q <= fails_q + 2'h1;
						sec_q <= 8'h00; // Retry
					end
				end
			end
			boiler_pkg::ST_RUN:
			begin
				if (!heat_call)
					st_q <= boiler_pkg::ST_IDLE;
				else if (!air_proven)
				begin
					ev[boiler_pkg::IRQ_AIR] <= 1'b1;
					st_q <= boiler_pkg::ST_PROVE; // RULE17
					sec_q <= 8'h00;
				end
				else if (!flame_sense)
				begin
					ev[boiler_pkg::IRQ_FLAME] <= 1'b1;
					st_q <= boiler_pkg::ST_TRIAL; // RULE14
					sec_q <= 8'h00;
				end
				else if (limit_q)
				begin
					ev[boiler_pkg::IRQ_LIMIT] <= 1'b1;
					st_q <= boiler_pkg::ST_PURGE; // RULE3
				end
			end
			boiler_pkg::ST_LOCK:
				st_q <= boiler_pkg::ST_LOCK; // RULE18
			default:
				st_q <= boiler_pkg::ST_IDLE;
			endcase
		end
	end

	// Pump overrun after call ends; zero means stop at once
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ovr_cnt_q <= 8'h00;
		else if (heat_call)
			ovr_cnt_q <= ovr_q; // RULE11
		else if (tk.sec_tick && ovr_cnt_q != 8'h00)
			ovr_cnt_q <= ovr_cnt_q - 8'h01; // RULE12
	end

	// Actuator outputs, all registered
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			blower_on <= 1'b0;
			boiler_circulator_output <= 1'b0;
			gas_valve_on <= 1'b0;
			igniter_on <= 1'b0;
		end
		else
		begin
			boiler_circulator_output <= heat_call ||
				(ovr_cnt_q != 8'h00); // RULE1 RULE11
			blower_on <= (st_q == boiler_pkg::ST_PROVE) ||
				(st_q == boiler_pkg::ST_TRIAL) ||
				(st_q == boiler_pkg::ST_RUN); // RULE1 RULE19
			// Gas only with igniter or proven flame, never without air
			igniter_on <= (st_q == boiler_pkg::ST_TRIAL) &&
				air_proven; // RULE19
			gas_valve_on <= ((st_q == boiler_pkg::ST_TRIAL) ||
				(st_q == boiler_pkg::ST_RUN)) &&
				air_proven && heat_call; // RULE17 RULE18
		end
	end

	// Three-character display: error codes take priority
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			display_chars <= {boiler_pkg::CH_SP, boiler_pkg::CH_SP,
				boiler_pkg::CH_SP};
		else if (st_q == boiler_pkg::ST_LOCK)
			display_chars <= {boiler_pkg::CH_E, boiler_pkg::CH_6,
				boiler_pkg::CH_2}; // RULE2 RULE15
		else if (air_err_q)
			display_chars <= {boiler_pkg::CH_E, boiler_pkg::CH_2,
				boiler_pkg::CH_9}; // RULE16
		else if (limit_q)
			display_chars <= {boiler_pkg::CH_H, boiler_pkg::CH_L,
				boiler_pkg::CH_SP};
		else if (st_q == boiler_pkg::ST_PURGE)
			display_chars <= {boiler_pkg::CH_P, boiler_pkg::CH_SP,
				boiler_pkg::CH_SP};
		else
			display_chars <= {boiler_pkg::CH_S, boiler_pkg::CH_SP,
				boiler_pkg::CH_0}; // RULE2
	end

	// Gas never open without igniter or run state
	property p_gas_ign;
		@(posedge clk) disable iff (!arst_n)
		gas_valve_on |-> $past(st_q) == boiler_pkg::ST_TRIAL ||
			$past(st_q) == boiler_pkg::ST_RUN;
	endproperty
	a_gas_ign: assert property (p_gas_ign) // RULE19
		else $error("gas open outside trial or run");

	// Lockout holds gas and igniter off
	property p_lock;
		@(posedge clk) disable iff (!arst_n)
		st_q == boiler_pkg::ST_LOCK |=> !gas_valve_on && !igniter_on
			&& st_q == boiler_pkg::ST_LOCK;
	endproperty
	a_lock: assert property (p_lock) // RULE18
		else $error("lockout leaked");

	// Lockout shows 62
	property p_e62;
		@(posedge clk) disable iff (!arst_n)
		st_q == boiler_pkg::ST_LOCK |=> display_chars == 24'h45_3632;
	endproperty
	a_e62: assert property (p_e62) // RULE15
		else $error("lockout code wrong");

	// Airflow loss closes gas next cycle
	property p_air;
		@(posedge clk) disable iff (!arst_n)
		!air_proven |=> !gas_valve_on;
	endproperty
	a_air: assert property (p_air) // RULE17
		else $error("gas open without airflow");

	// Limit trips above setpoint
	property p_lim;
		@(posedge clk) disable iff (!arst_n)
		water_temp > hilim_q |=> limit_q;
	endproperty
	a_lim: assert property (p_lim) // RULE3
		else $error("limit missed");

	// Circulator runs while heat called
	property p_circ;
		@(posedge clk) disable iff (!arst_n)
		heat_call |=> boiler_circulator_output;
	endproperty
	a_circ: assert property (p_circ) // RULE11
		else $error("circulator off during call");

	// Overrun never exceeds its maximum
	property p_ovr;
		@(posedge clk) disable iff (!arst_n)
		1'b1 |-> ovr_q <= boiler_pkg::OVR_MAX && ovr_cnt_q <= ovr_q;
	endproperty
	a_ovr: assert property (p_ovr) // RULE12
		else $error("overrun out of range");

	// Purge keeps burner off
	property p_purge;
		@(posedge clk) disable iff (!arst_n)
		(st_q == boiler_pkg::ST_PURGE) [*2] |-> !gas_valve_on;
	endproperty
	a_purge: assert property (p_purge) // RULE5
		else $error("burner on during purge");
endmodule : boiler_sequence_controller

//--- rtl/boiler_pkg.sv
// Constants, timing figures and display codes of the boiler sequencer
// Functional notes
// RULE1: Drive blower, circulator, gas valve, igniter outputs
// RULE2: Show status and errors on three characters
// RULE3: High limit 80-190F inhibits firing above
// RULE4: Limit clears below setpoint minus 10-30F
// RULE5: Purge runs circulator, burner off until release
// RULE6: Purge temperature and delay are configurable
// RULE7: Purge ends after 10F drop from start
// RULE8: Purge ends when cooling faster than 5F/min
// RULE9: Hot water draw bypasses purge while active
// RULE10: Purge may be disabled entirely by setting
// RULE11: Circulator overruns after call for heat ends
// RULE12: Overrun 0-120 s whole seconds, default 60
// RULE13: Installer sets overrun zero with zone valves
// RULE14: Flame judged from sensing input during trials
// RULE15: Three failed trials lock out, show 62
// RULE16: Airflow switch must close, else show 29
// RULE17: Airflow loss during firing closes gas valve
// RULE18: Lockout persists until reset, valve igniter off
// RULE19: Prove airflow first, gas only with igniter
package boiler_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_HILIM = 8'h00;
	localparam logic [7:0] OFF_DIFF = 8'h04;
	localparam logic [7:0] OFF_PTEMP = 8'h08;
	localparam logic [7:0] OFF_PDLY = 8'h0C;
	localparam logic [7:0] OFF_OVR = 8'h10;
	localparam logic [7:0] OFF_CTRL = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ = 8'h1C;
	localparam logic [7:0] OFF_MASK = 8'h20;
	localparam logic [7:0] OFF_DISP = 8'h24;
	// Setting limits and reset values, degrees F and seconds
	localparam logic [7:0] HILIM_MIN = 8'h50;
	localparam logic [7:0] HILIM_MAX = 8'hBE;
	localparam logic [7:0] HILIM_RST = 8'hB4;
	localparam logic [7:0] DIFF_MIN = 8'h0A;
	localparam logic [7:0] DIFF_MAX = 8'h1E;
	localparam logic [7:0] DIFF_RST = 8'h0F;
	localparam logic [7:0] PTEMP_RST = 8'h8C;
	localparam logic [7:0] PDLY_RST = 8'h3C;
	localparam logic [7:0] OVR_MAX = 8'h78;
	localparam logic [7:0] OVR_RST = 8'h3C;
	localparam logic [7:0] PURGE_DROP = 8'h0A;
	localparam logic [7:0] RATE_DROP = 8'h05;
	localparam logic [1:0] MAX_TRIALS = 2'h3;
	// Control register bit positions
	localparam int CTRL_PURGE_EN = 0;
	// Interrupt bit positions
	localparam int IRQ_LOCK = 0;
	localparam int IRQ_AIR = 1;
	localparam int IRQ_LIMIT = 2;
	localparam int IRQ_FLAME = 3;
	// Timing: clock rate and phase lengths
	localparam longint CLK_HZ = 125000000;
	localparam longint SEC_CYC = CLK_HZ;
	localparam int PROVE_S = 5;
	localparam int TRIAL_S = 4;
	localparam int RATE_S = 60;
	// Display characters (ASCII)
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_L = 8'h4C;
	localparam logic [7:0] CH_2 = 8'h32;
	localparam logic [7:0] CH_6 = 8'h36;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_0 = 8'h30;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_PURGE, ST_PROVE, ST_TRIAL, ST_RUN, ST_LOCK
	} seq_t;
endpackage : boiler_pkg

//--- rtl/tick_if.sv
// Second tick carrier between sequencer modules
`timescale 1ns/1ns
interface tick_if;
	logic sec_tick; // One-cycle pulse each second
	modport src (output sec_tick);
	modport dst (input sec_tick);
endinterface : tick_if

//--- rtl/sec_divider.sv
// Divider producing a one-second enable pulse from the system clock
`timescale 1ns/1ns
module sec_divider #(
	parameter longint CYC = boiler_pkg::SEC_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	tick_if.src tk
);
	logic [31:0] cnt_q; // Cycle counter
	// Count to one second, pulse, restart
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 32'h0000_0000;
			tk.sec_tick <= 1'b0;
		end
		else if (cnt_q >= 32'(CYC - 1))
		begin
			cnt_q <= 32'h0000_0000;
			tk.sec_tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tk.sec_tick <= 1'b0;
		end
	end
endmodule : sec_divider

//--- rtl/temp_rate.sv
// Cooling-rate detector: drop over a fixed one-minute window
`timescale 1ns/1ns
module temp_rate (
	input wire logic clk,
	input wire logic arst_n,
	tick_if.dst tk,
	input wire logic [7:0] temp,
	input wire logic run,
	output logic fast_cool
);
	logic [7:0] ref_q; // Temperature at window start
	logic [6:0] sec_q; // Seconds into window
	// Sample once a minute while circulator runs; a drop of more than
	// five degrees within the window counts as fast cooling
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ref_q <= 8'h00;
			sec_q <= 7'h00;
			fast_cool <= 1'b0;
		end
		else if (!run)
		begin
			// Window restarts whenever the pump stops
			ref_q <= temp;
			sec_q <= 7'h00;
			fast_cool <= 1'b0;
		end
		else if (tk.sec_tick)
		begin
			if (sec_q >= 7'(boiler_pkg::RATE_S - 1))
			begin
				sec_q <= 7'h00;
				ref_q <= temp;
			end
			else
			begin
				sec_q <= sec_q + 7'h01;
			end
			// Partial-window drop above the limit is already too fast
			fast_cool <= (ref_q > temp) &&
				((ref_q - temp) > boiler_pkg::RATE_DROP); // RULE8
		end
	end
endmodule : temp_rate

//--- tb/boiler_plant_model.sv
// Far-side plant model: airflow switch and burner flame
`timescale 1ns/1ns
module boiler_plant_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic blower_on,
	input wire logic gas_valve_on,
	input wire logic igniter_on,
	input wire logic air_ok,
	input wire logic flame_ok,
	output logic air_proven,
	output logic flame_sense
);
	logic [1:0] spin_q; // Blower spin-up pipeline
	logic lit_q; // Flame established
	// Switch closes only after two cycles of blower with clear vent
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			spin_q <= 2'h0;
		else
			spin_q <= {spin_q[0], blower_on & air_ok};
	end
	assign air_proven = spin_q[1];
	// Flame needs spark with gas; once lit it holds while gas flows
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			lit_q <= 1'b0;
		else
			lit_q <= gas_valve_on & flame_ok & (lit_q | igniter_on);
	end
	assign flame_sense = lit_q;
endmodule : boiler_plant_model

//--- tb/boiler_sequence_controller_test.sv
// Self-checking bench for the boiler sequencer
`timescale 1ns/1ns
module boiler_sequence_controller_test;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, water_temp;
	logic [31:0] pwdata, prdata;
	logic heat_call, air_proven, flame_sense, hot_water_draw_input;
	logic blower_on, circ_on, gas_valve_on, igniter_on, irq;
	logic [23:0] display_chars;
	logic air_ok, flame_ok; // Plant fault controls
	int mismatches, checks;
	logic [31:0] rq; // Last read data
	logic re; // Last slave error
	// Shrink the second so timed phases stay short
	defparam dut.u_div.CYC = 100;
	boiler_sequence_controller dut (.clk(clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .heat_call(heat_call),
		.water_temp(water_temp), .air_proven(air_proven),
		.flame_sense(flame_sense),
		.hot_water_draw_input(hot_water_draw_input),
		.blower_on(blower_on), .boiler_circulator_output(circ_on),
		.gas_valve_on(gas_valve_on), .igniter_on(igniter_on),
		.display_chars(display_chars), .irq(irq));
	boiler_plant_model plant (.clk(clk), .arst_n(arst_n),
		.blower_on(blower_on), .gas_valve_on(gas_valve_on),
		.igniter_on(igniter_on), .air_ok(air_ok), .flame_ok(flame_ok),
		.air_proven(air_proven), .flame_sense(flame_sense));
	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// Value comparison
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rq, e);
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// Poll the state field, bounded by n extra reads
	task wait_st(input logic [2:0] s, input int n);
		int i;
		i = 0;
		apb(1'b0, boiler_pkg::OFF_STAT, 32'h0000_0000);
		while (rq[2:0] !== s && i < n)
		begin
			apb(1'b0, boiler_pkg::OFF_STAT, 32'h0000_0000);
			i++;
		end
		chk({29'h0, rq[2:0]}, {29'h0, s});
	endtask : wait_st
	// Hang guard: a few times the expected run length
	initial
	begin
		repeat (60000) @(posedge clk);
		mismatches++;
		results;
	end
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		heat_call = 1'b0;
		water_temp = 8'h96;
		hot_water_draw_input = 1'b0;
		air_ok = 1'b1;
		flame_ok = 1'b1;
		mismatches = 0;
		checks = 0;
		cyc(16);
		arst_n <= 1'b1;
		// Reset values, clamping and an unmapped place
		rd(boiler_pkg::OFF_HILIM, {24'h0, boiler_pkg::HILIM_RST});
		rd(boiler_pkg::OFF_OVR, 32'h0000_003C);
		rd(boiler_pkg::OFF_CTRL, 32'h0000_0001);
		rd(boiler_pkg::OFF_PTEMP, {24'h0, boiler_pkg::PTEMP_RST});
		chk({8'h00, display_chars}, {8'h00, boiler_pkg::CH_S,
			boiler_pkg::CH_SP, boiler_pkg::CH_0});
		wr(boiler_pkg::OFF_HILIM, 32'h0000_00FF);
		rd(boiler_pkg::OFF_HILIM, 32'h0000_00BE);
		wr(boiler_pkg::OFF_HILIM, 32'h0000_0040);
		rd(boiler_pkg::OFF_HILIM, 32'h0000_0050);
		wr(boiler_pkg::OFF_DIFF, 32'h0000_0005);
		rd(boiler_pkg::OFF_DIFF, 32'h0000_000A);
		wr(boiler_pkg::OFF_DIFF, 32'h0000_0040);
		rd(boiler_pkg::OFF_DIFF, 32'h0000_001E);
		wr(boiler_pkg::OFF_OVR, 32'h0000_00FF);
		rd(boiler_pkg::OFF_OVR, 32'h0000_0078);
		wr(8'h28, 32'h0000_00FF);
		chk({31'h0, re}, 32'h0000_0001);
		rd(8'h28, 32'h0000_0000);
		wr(boiler_pkg::OFF_HILIM, 32'h0000_00B4);
		wr(boiler_pkg::OFF_DIFF, 32'h0000_000F);
		wr(boiler_pkg::OFF_OVR, 32'h0000_0002);
		wr(boiler_pkg::OFF_CTRL, 32'h0000_0000);
		// Purge off: fire at once, then lose airflow while firing
		heat_call <= 1'b1;
		cyc(5);
		chk({31'h0, blower_on}, 32'h0000_0001);
		wait_st(boiler_pkg::ST_RUN, 300);
		chk({31'h0, gas_valve_on & air_proven}, 32'h0000_0001);
		chk({31'h0, circ_on}, 32'h0000_0001);
		air_ok <= 1'b0;
		cyc(6);
		chk({31'h0, gas_valve_on}, 32'h0000_0000);
		air_ok <= 1'b1;
		heat_call <= 1'b0;
		cyc(50);
		chk({31'h0, circ_on}, 32'h0000_0001);
		cyc(300);
		chk({31'h0, circ_on}, 32'h0000_0000);
		// Zero overrun stops the pump straight away
		wr(boiler_pkg::OFF_OVR, 32'h0000_0000);
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_RUN, 300);
		heat_call <= 1'b0;
		cyc(8);
		chk({31'h0, circ_on}, 32'h0000_0000);
		// Purge held by a three second delay
		wr(boiler_pkg::OFF_CTRL, 32'h0000_0001);
		wr(boiler_pkg::OFF_PDLY, 32'h0000_0003);
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_PURGE, 10);
		chk({29'h0, circ_on, blower_on, gas_valve_on}, 32'h0000_0004);
		cyc(150);
		wait_st(boiler_pkg::ST_PURGE, 0);
		wait_st(boiler_pkg::ST_RUN, 300);
		heat_call <= 1'b0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		// Slow 10F fall ends purge; the 5F step alone must not
		wr(boiler_pkg::OFF_PDLY, 32'h0000_0064);
		water_temp <= 8'hA0;
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_PURGE, 10);
		water_temp <= 8'h9B;
		cyc(6500);
		wait_st(boiler_pkg::ST_PURGE, 0);
		water_temp <= 8'h96;
		wait_st(boiler_pkg::ST_TRIAL, 30);
		chk({31'h0, igniter_on}, 32'h0000_0001);
		heat_call <= 1'b0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		// Fast 6F fall ends purge
		water_temp <= 8'hA0;
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_PURGE, 10);
		water_temp <= 8'h9A;
		wait_st(boiler_pkg::ST_TRIAL, 60);
		heat_call <= 1'b0;
		water_temp <= 8'hA0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		// Hot water draw skips purge, and purge returns after it
		hot_water_draw_input <= 1'b1;
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_TRIAL, 20);
		heat_call <= 1'b0;
		hot_water_draw_input <= 1'b0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_PURGE, 10);
		// Raising the purge temperature above the water releases the burner
		wr(boiler_pkg::OFF_PTEMP, 32'h0000_00A5);
		wait_st(boiler_pkg::ST_TRIAL, 30);
		heat_call <= 1'b0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		// High limit 180 with 15F differential
		wr(boiler_pkg::OFF_CTRL, 32'h0000_0000);
		water_temp <= 8'hB9;
		heat_call <= 1'b1;
		cyc(100);
		apb(1'b0, boiler_pkg::OFF_STAT, 32'h0000_0000);
		chk({31'h0, rq[12] & ~gas_valve_on}, 32'h0000_0001);
		water_temp <= 8'hA6;
		cyc(20);
		chk({31'h0, gas_valve_on}, 32'h0000_0000);
		water_temp <= 8'hA4;
		wait_st(boiler_pkg::ST_TRIAL, 40);
		heat_call <= 1'b0;
		wait_st(boiler_pkg::ST_IDLE, 20);
		// Airflow never proves: error 29, masked then unmasked
		wr(boiler_pkg::OFF_IRQ, 32'h0000_000F);
		wr(boiler_pkg::OFF_MASK, 32'h0000_0000);
		air_ok <= 1'b0;
		heat_call <= 1'b1;
		cyc(700);
		chk({31'h0, gas_valve_on}, 32'h0000_0000);
		chk({8'h00, display_chars}, {8'h00, boiler_pkg::CH_E,
			boiler_pkg::CH_2, boiler_pkg::CH_9});
		apb(1'b0, boiler_pkg::OFF_IRQ, 32'h0000_0000);
		chk({31'h0, rq[1] & ~irq}, 32'h0000_0001);
		wr(boiler_pkg::OFF_MASK, 32'h0000_0002);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0001);
		heat_call <= 1'b0;
		air_ok <= 1'b1;
		wait_st(boiler_pkg::ST_IDLE, 20);
		wr(boiler_pkg::OFF_IRQ, 32'h0000_0002);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000);
		// No flame on three trials: lockout until reset
		wr(boiler_pkg::OFF_MASK, 32'h0000_0001);
		flame_ok <= 1'b0;
		heat_call <= 1'b1;
		wait_st(boiler_pkg::ST_LOCK, 800);
		chk({8'h00, display_chars}, {8'h00, boiler_pkg::CH_E,
			boiler_pkg::CH_6, boiler_pkg::CH_2});
		chk({31'h0, irq}, 32'h0000_0001);
		heat_call <= 1'b0;
		cyc(300);
		chk({30'h0, gas_valve_on, igniter_on}, 32'h0000_0000);
		wait_st(boiler_pkg::ST_LOCK, 0);
		arst_n <= 1'b0;
		cyc(2);
		arst_n <= 1'b1;
		flame_ok <= 1'b1;
		wait_st(boiler_pkg::ST_IDLE, 0);
		results;
	end
endmodule : boiler_sequence_controller_test
